/* design/fpc_host.sv */
// Purpose: host-side controller issuing program/erase command sequences to a banked NOR flash
// Assumes: flash inputs synchronous to pclk; software drives it over APB
// Notes:   one sequence at a time; ready_busy_out high means the addressed bank is ready
//
// Summary of operation
// - program is two unlock writes, A0h set-up, then address and data
// - hardware reset aborts a program; software reissues it afterwards
// - bypass entry is two unlock writes then 20h
// - bypass program is A0h then address and data, repeatable
// - bypass exit is 90h at bank address, then 00h anywhere
// - chip erase is six writes ending with 10h
// - sector erase is six writes ending with sector address and 30h
// - more sectors may be added while the 80 us window is open
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"

module fpc_host #(
   parameter int unsigned WINDOW_CYCLES = `FPC_WINDOW_CYCLES
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic [7:0]            paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   output fpc_pkg::fpc_flash_out_t    flash_out,
   output logic      [15:0]           flash_dq_out,
   output logic                       flash_dq_oe,
   input  wire logic [15:0]           flash_dq_in,
   input  wire logic                  ready_busy_out
);
   import fpc_pkg::*;

   localparam logic [15:0] WE_LOW_CYC  = 16'(`FPC_CYC(`FPC_WE_LOW_NS));
   localparam logic [15:0] WE_HIGH_CYC = 16'(`FPC_CYC(`FPC_WE_HIGH_NS));
   localparam logic [15:0] READ_CYC    = 16'(`FPC_CYC(`FPC_READ_NS));
   localparam logic [15:0] RST_CYC     = 16'(`FPC_CYC(`FPC_RST_NS));
   localparam logic [15:0] SETTLE_CYC  = 16'(`FPC_CYC(`FPC_SETTLE_NS));
   localparam logic [15:0] WIN_CYC     = 16'(WINDOW_CYCLES);

   fpc_state_t  state;
   fpc_op_t     op;
   logic [2:0]  step;
   logic [15:0] cnt;
   logic [15:0] win_cnt;
   logic [1:0]  ctrl;
   logic [21:0] tgt_addr;
   logic [15:0] tgt_data;
   logic [15:0] rd_data;
   logic        bypass_mode;
   logic        erase_active;
   logic        erase_busy_seen;
   logic        suspended;
   logic        done_flag;
   logic        refused_flag;
   fpc_cycle_t  cyc;
   logic [7:0]  status;

   // unlock address for the current bus width
   function automatic logic [21:0] unlock_addr(input logic second, input logic byte_mode);
      if (byte_mode)
         return second ? `FPC_UNLOCK2_BYTE : `FPC_UNLOCK1_BYTE;
      return second ? `FPC_UNLOCK2_WORD : `FPC_UNLOCK1_WORD;
   endfunction

   // address/data of one write cycle of a sequence
   function automatic fpc_cycle_t cycle_of(input fpc_op_t o, input logic [2:0] s,
                                           input logic bm, input logic [21:0] a,
                                           input logic [15:0] d);
      fpc_cycle_t c;
      c.last = 1'b0;
      c.addr = unlock_addr(1'b0, bm);
      c.data = `FPC_KEY1;
      case (o)
         OP_BYP_PROG: begin
            c.addr = a;
            c.data = (s == 3'h0) ? `FPC_CODE_PROG : d;
            c.last = (s == 3'h1);
         end
         OP_BYP_EXIT: begin
            c.addr = a;
            c.data = (s == 3'h0) ? `FPC_CODE_BYP_EXIT1 : `FPC_CODE_BYP_EXIT2;
            c.last = (s == 3'h1);
         end
         OP_SECT_ADD: begin
            c.addr = a;
            c.data = `FPC_CODE_SECTOR;
            c.last = 1'b1;
         end
         OP_SUSPEND: begin
            c.addr = a;
            c.data = `FPC_CODE_SUSPEND;
            c.last = 1'b1;
         end
         default: begin                                          // unlock-led sequences
            case (s)
               3'h0: c.data = `FPC_KEY1;
               3'h1: begin
                  c.addr = unlock_addr(1'b1, bm);
                  c.data = `FPC_KEY2;
               end
               3'h2: begin
                  if (o == OP_PROG)
                     c.data = `FPC_CODE_PROG;
                  else if (o == OP_BYP_ENTER)
                     c.data = `FPC_CODE_BYPASS;
                  else
                     c.data = `FPC_CODE_ERASE;
                  c.last = (o == OP_BYP_ENTER);
               end
               3'h3: begin
                  if (o == OP_PROG) begin
                     c.addr = a;
                     c.data = d;
                     c.last = 1'b1;
                  end
               end
               3'h4: begin
                  c.addr = unlock_addr(1'b1, bm);
                  c.data = `FPC_KEY2;
               end
               default: begin
                  c.addr = (o == OP_SECT) ? a : unlock_addr(1'b0, bm);
                  c.data = (o == OP_SECT) ? `FPC_CODE_SECTOR : `FPC_CODE_CHIP;
                  c.last = 1'b1;
               end
            endcase
         end
      endcase
      if (bm)
         c.data = c.data & `FPC_BYTE_MASK;
      return c;
   endfunction

   // which operations may start in the present flash mode
   function automatic logic legal(input fpc_op_t o, input logic byp, input logic ers,
                                  input logic win);
      if (o == OP_READ || o == OP_HWRESET)
         return 1'b1;
      if (byp)
         return (o == OP_BYP_PROG) || (o == OP_BYP_EXIT);
      if (ers)
         return (o == OP_SUSPEND) || (o == OP_SECT_ADD && win);
      return (o == OP_PROG) || (o == OP_BYP_ENTER) || (o == OP_CHIP) || (o == OP_SECT);
   endfunction

   // apb strobes and command acceptance
   logic    wr_en;
   logic    cmd_wr;
   logic    accept;
   logic    seq_end;
   fpc_op_t new_op;
   logic    bypass_eff;
   assign wr_en      = psel & penable & pwrite;
   assign cmd_wr     = wr_en && (paddr == `FPC_OFS_CMD);
   assign new_op     = fpc_op_t'(pwdata[3:0]);
   assign bypass_eff = bypass_mode | ctrl[`FPC_CTRL_ACCEL];
   assign accept     = cmd_wr && (new_op == OP_HWRESET ||
                       (state == ST_IDLE && legal(new_op, bypass_eff, erase_active,
                                                  win_cnt != 16'h0000)));
   assign seq_end    = (state == ST_RELEASE) && (cnt == WE_HIGH_CYC - 16'h0001) && cyc.last;
   assign pready     = 1'b1;

   // register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl     <= `FPC_CTRL_RESET;
         tgt_addr <= 22'h000000;
         tgt_data <= 16'h0000;
      end else if (wr_en) begin
         if (paddr == `FPC_OFS_CTRL)
            ctrl <= pwdata[1:0];
         if (paddr == `FPC_OFS_ADDR)
            tgt_addr <= pwdata[21:0];
         if (paddr == `FPC_OFS_DATA)
            tgt_data <= pwdata[15:0];
      end
   end

   // sequence engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         op    <= OP_READ;
         step  <= 3'h0;
         cnt   <= 16'h0000;
      end else if (accept) begin
         op    <= new_op;
         step  <= 3'h0;
         cnt   <= 16'h0000;
         if (new_op == OP_HWRESET)
            state <= ST_RST;
         else if (new_op == OP_READ)
            state <= ST_READ;
         else
            state <= ST_ASSERT;
      end else begin
         case (state)
            ST_ASSERT: state <= ST_STROBE;
            ST_STROBE: begin
               cnt <= cnt + 16'h0001;
               if (cnt == WE_LOW_CYC - 16'h0001) begin
                  cnt   <= 16'h0000;
                  state <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               cnt <= cnt + 16'h0001;
               if (cnt == WE_HIGH_CYC - 16'h0001) begin
                  cnt  <= 16'h0000;
                  step <= step + 3'h1;
                  if (!cyc.last)
                     state <= ST_ASSERT;
                  else if (op == OP_PROG || op == OP_BYP_PROG || op == OP_CHIP)
                     state <= ST_WAIT;
                  else
                     state <= ST_IDLE;
               end
            end
            ST_WAIT: begin
               if (cnt < SETTLE_CYC)
                  cnt <= cnt + 16'h0001;
               else if (ready_busy_out)
                  state <= ST_IDLE;
            end
            ST_READ, ST_RST: begin
               cnt <= cnt + 16'h0001;
               if (cnt == ((state == ST_READ) ? READ_CYC : RST_CYC) - 16'h0001)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // current cycle latched on entry to each write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cyc <= '0;
      else if (state == ST_ASSERT)
         cyc <= cycle_of(op, step, ctrl[`FPC_CTRL_BYTE], tgt_addr, tgt_data);
   end

   // pin drive from flops; address and data held across the strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_out    <= '{addr: 22'h000000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                           reset_n: 1'b1, byte_word_width_select: 1'b0,
                           protect_accelerate_pin: 1'b0};
         flash_dq_out <= 16'h0000;
         flash_dq_oe  <= 1'b0;
         rd_data      <= 16'h0000;
      end else begin
         flash_out.byte_word_width_select <= ~ctrl[`FPC_CTRL_BYTE];  // high selects word
         flash_out.protect_accelerate_pin <= ctrl[`FPC_CTRL_ACCEL];
         flash_out.reset_n <= (state != ST_RST);
         flash_out.we_n    <= !(state == ST_STROBE);
         flash_out.ce_n    <= !(state == ST_STROBE || state == ST_RELEASE || state == ST_READ);
         flash_out.oe_n    <= !(state == ST_READ);
         flash_dq_oe       <= (state == ST_STROBE || state == ST_RELEASE);
         if (state == ST_STROBE) begin
            flash_out.addr <= cyc.addr;
            flash_dq_out   <= cyc.data;
         end else if (state == ST_READ) begin
            flash_out.addr <= tgt_addr;
            if (cnt == READ_CYC - 16'h0001)
               rd_data <= ctrl[`FPC_CTRL_BYTE] ? (flash_dq_in & `FPC_BYTE_MASK) : flash_dq_in;
         end
      end
   end

   // flash mode tracking: bypass, erase, window timer, suspend
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bypass_mode     <= 1'b0;
         erase_active    <= 1'b0;
         erase_busy_seen <= 1'b0;
         suspended       <= 1'b0;
         win_cnt         <= 16'h0000;
      end else if (accept && new_op == OP_HWRESET) begin
         bypass_mode     <= 1'b0;
         erase_active    <= 1'b0;
         erase_busy_seen <= 1'b0;
         suspended       <= 1'b0;
         win_cnt         <= 16'h0000;
      end else begin
         if (win_cnt != 16'h0000)
            win_cnt <= win_cnt - 16'h0001;
         if (erase_active && !ready_busy_out)
            erase_busy_seen <= 1'b1;
         if (erase_active && erase_busy_seen && ready_busy_out && win_cnt == 16'h0000) begin
            erase_active    <= 1'b0;
            erase_busy_seen <= 1'b0;
         end
         if (seq_end) begin
            case (op)
               OP_BYP_ENTER: bypass_mode <= 1'b1;
               OP_BYP_EXIT:  bypass_mode <= 1'b0;
               OP_SECT, OP_SECT_ADD: begin
                  erase_active <= 1'b1;
                  // the flash started timing at the write-enable rise, a release ago
                  win_cnt      <= WIN_CYC - (WE_HIGH_CYC - 16'h0001);
               end
               OP_SUSPEND: begin
                  win_cnt         <= 16'h0000;
                  erase_active    <= 1'b0;
                  erase_busy_seen <= 1'b0;
                  suspended       <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   // sticky done and refused flags; hardware set wins over software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_flag    <= 1'b0;
         refused_flag <= 1'b0;
      end else begin
         if (wr_en && paddr == `FPC_OFS_STATUS && pwdata[`FPC_ST_DONE])
            done_flag <= 1'b0;
         if (wr_en && paddr == `FPC_OFS_STATUS && pwdata[`FPC_ST_REFUSED])
            refused_flag <= 1'b0;
         if ((state == ST_WAIT && cnt >= SETTLE_CYC && ready_busy_out) ||
             (seq_end && !(op == OP_PROG || op == OP_BYP_PROG || op == OP_CHIP)) ||
             (state == ST_READ && cnt == READ_CYC - 16'h0001) ||
             (state == ST_RST && cnt == RST_CYC - 16'h0001))
            done_flag <= 1'b1;
         if (cmd_wr && !accept)
            refused_flag <= 1'b1;
      end
   end

   // status word and apb read data, captured in the setup cycle
   assign status = {refused_flag, done_flag, ready_busy_out, suspended,
                    win_cnt != 16'h0000, erase_active, bypass_eff, state != ST_IDLE};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= 1'b0;
         case (paddr)
            `FPC_OFS_CTRL:   prdata <= {30'h00000000, ctrl};
            `FPC_OFS_ADDR:   prdata <= {10'h000, tgt_addr};
            `FPC_OFS_DATA:   prdata <= {16'h0000, tgt_data};
            `FPC_OFS_CMD:    prdata <= {28'h0000000, op};
            `FPC_OFS_STATUS: prdata <= {24'h000000, status};
            `FPC_OFS_RDATA:  prdata <= {16'h0000, rd_data};
            default: begin
               prdata  <= 32'h00000000;
               pslverr <= 1'b1;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* shared/fpc_regs.svh */
// Purpose: register offsets, field positions, reset values and timing counts of the
//          flash command controller
// Assumes: pclk at 200 MHz, 32-bit APB data, one word per register
// Notes:   word-mode unlock addresses; byte mode uses the doubled forms
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// register byte offsets
`define FPC_OFS_CTRL        8'h00
`define FPC_OFS_ADDR        8'h04
`define FPC_OFS_DATA        8'h08
`define FPC_OFS_CMD         8'h0C
`define FPC_OFS_STATUS      8'h10
`define FPC_OFS_RDATA       8'h14

// ctrl fields
`define FPC_CTRL_BYTE       0
`define FPC_CTRL_ACCEL      1
`define FPC_CTRL_RESET      2'h0

// status fields
`define FPC_ST_BUSY         0
`define FPC_ST_BYPASS       1
`define FPC_ST_ERASE        2
`define FPC_ST_WINDOW       3
`define FPC_ST_SUSPEND      4
`define FPC_ST_RDY          5
`define FPC_ST_DONE         6
`define FPC_ST_REFUSED      7

// flash bus values
`define FPC_UNLOCK1_WORD    22'h000555
`define FPC_UNLOCK2_WORD    22'h0002AA
`define FPC_UNLOCK1_BYTE    22'h000AAA
`define FPC_UNLOCK2_BYTE    22'h000555
`define FPC_KEY1            16'h00AA
`define FPC_KEY2            16'h0055
`define FPC_CODE_PROG       16'h00A0
`define FPC_CODE_ERASE      16'h0080
`define FPC_CODE_CHIP       16'h0010
`define FPC_CODE_SECTOR     16'h0030
`define FPC_CODE_BYPASS     16'h0020
`define FPC_CODE_BYP_EXIT1  16'h0090
`define FPC_CODE_BYP_EXIT2  16'h0000
`define FPC_CODE_SUSPEND    16'h00B0
`define FPC_BYTE_MASK       16'h00FF

// timing, in ns as given (erase window in us), and derived cycle counts (least times round up)
`define FPC_CLK_NS          5
`define FPC_CYC(ns)         (((ns) + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_WE_LOW_NS       35
`define FPC_WE_HIGH_NS      30
`define FPC_READ_NS         80
`define FPC_RST_NS          500
`define FPC_SETTLE_NS       100
`define FPC_WINDOW_US       80
`define FPC_WINDOW_CYCLES   ((`FPC_WINDOW_US * 1000) / `FPC_CLK_NS)

`endif

/* shared/fpc_pkg.sv */
// Purpose: types shared by the flash command controller
// Assumes: constants come from fpc_regs.svh
// Notes:   op codes are the values software writes to the command register
package fpc_pkg;

   // operations software can start
   typedef enum logic [3:0] {
      OP_PROG      = 4'h0,
      OP_BYP_ENTER = 4'h1,
      OP_BYP_PROG  = 4'h2,
      OP_BYP_EXIT  = 4'h3,
      OP_CHIP      = 4'h4,
      OP_SECT      = 4'h5,
      OP_SECT_ADD  = 4'h6,
      OP_SUSPEND   = 4'h7,
      OP_READ      = 4'h8,
      OP_HWRESET   = 4'h9
   } fpc_op_t;

   // engine states, gray along idle-assert-strobe-release-wait
   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_ASSERT  = 3'h1,
      ST_STROBE  = 3'h3,
      ST_RELEASE = 3'h2,
      ST_WAIT    = 3'h6,
      ST_READ    = 3'h7,
      ST_RST     = 3'h5
   } fpc_state_t;

   // one bus write cycle of a command sequence
   typedef struct packed {
      logic [21:0] addr;
      logic [15:0] data;
      logic        last;
   } fpc_cycle_t;

   // flash control pins driven by the controller
   typedef struct packed {
      logic [21:0] addr;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        reset_n;
      logic        byte_word_width_select;
      logic        protect_accelerate_pin;
   } fpc_flash_out_t;

endpackage

/* verification/fpc_host_asserts.sv */
// Purpose: port-level checks of the flash command controller
// Assumes: sees only the ports of fpc_host, one clock domain
// Notes:   bound to fpc_host at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module fpc_host_asserts (
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic [7:0]              paddr,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [31:0]             pwdata,
   input wire fpc_pkg::fpc_flash_out_t flash_out,
   input wire logic [15:0]             flash_dq_out,
   input wire logic                    flash_dq_oe
);
   import fpc_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // write strobes only reach a selected flash and drive the data bus
   a_we_with_ce: assert property (!flash_out.we_n |-> !flash_out.ce_n)
      else $error("write strobe without chip select");
   a_we_drives_dq: assert property (!flash_out.we_n |-> flash_dq_oe && flash_out.oe_n)
      else $error("write strobe without data drive");
   a_we_low_width: assert property ($fell(flash_out.we_n) |-> (!flash_out.we_n)[*6])
      else $error("write strobe too short");
   a_bus_held: assert property (!flash_out.we_n && !$past(flash_out.we_n) |->
      $stable(flash_out.addr) && $stable(flash_dq_out)) else $error("address moved in strobe");
   a_byte_mask: assert property (!flash_out.we_n && !flash_out.byte_word_width_select
      |-> flash_dq_out[15:8] == 8'h00) else $error("upper byte driven in byte mode");
   a_reset_quiet: assert property (!flash_out.reset_n |-> flash_out.we_n && flash_out.ce_n)
      else $error("flash accessed during reset");
   a_read_no_drive: assert property (!flash_out.oe_n |-> flash_out.we_n && !flash_dq_oe)
      else $error("read overlaps a write");
   a_accel_follow: assert property (psel && penable && pwrite && paddr == 8'h00 |-> ##2
      flash_out.protect_accelerate_pin == $past(pwdata[1], 2)) else $error("accel pin wrong");
   a_width_follow: assert property (psel && penable && pwrite && paddr == 8'h00 |-> ##2
      flash_out.byte_word_width_select == !$past(pwdata[0], 2)) else $error("width pin wrong");
   // main scenarios reached
   c_write: cover property ($fell(flash_out.we_n));
   c_reset: cover property (!flash_out.reset_n);
   c_accel: cover property ($rose(flash_out.protect_accelerate_pin));
endmodule
bind fpc_host fpc_host_asserts fpc_host_asserts_inst (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .flash_out(flash_out), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
`default_nettype wire

/* verification/fpc_flash_model.sv */
// Purpose: behavioural flash command decoder facing the controller
// Assumes: one bank; busy and window times counted in pclk cycles
// Notes:   unread bus returns inverted data so stale values never match
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_model #(
   parameter int W    = 200,
   parameter int BUSY = 40
) (
   input  wire logic                    pclk,
   input  wire fpc_pkg::fpc_flash_out_t flash_out,
   input  wire logic [15:0]             flash_dq_out,
   output logic      [15:0]             flash_dq_in = 16'h0000,
   output logic                         ready_busy_out
);
   import fpc_pkg::*;
   logic [15:0] mem [logic [21:0]];
   int          n = 0;
   int          busy = 0;
   int          wc = 0;
   logic        byp = 0;
   logic        win = 0;
   logic [21:0] u1;
   logic [21:0] u2;
   // unlock addresses depend on bus width
   assign u1 = flash_out.byte_word_width_select ? 22'h000555 : 22'h000AAA;
   assign u2 = flash_out.byte_word_width_select ? 22'h0002AA : 22'h000555;
   assign ready_busy_out = (busy == 0);
   // one command cycle, latched at write-enable rise
   task automatic wr(input logic [21:0] a, input logic [7:0] c, input logic [15:0] d);
      if (busy != 0) return;
      if (win) begin
         if (c == 8'h30) wc = W;
         else win = 0;
         return;
      end
      if (n == 2 && a == u1 && c == 8'h20) byp = 1;
      case (n)
         0: if (byp || flash_out.protect_accelerate_pin)
               n = (c == 8'hA0) ? 6 : (c == 8'h90) ? 7 : 0;
            else n = (a == u1 && c == 8'hAA) ? 1 : 0;
         1: n = (a == u2 && c == 8'h55) ? 2 : 0;
         2: n = (a != u1) ? 0 : (c == 8'hA0) ? 6 : (c == 8'h80) ? 3 : 0;
         3: n = (a == u1 && c == 8'hAA) ? 4 : 0;
         4: n = (a == u2 && c == 8'h55) ? 5 : 0;
         5: begin
               n = 0;
               if (a == u1 && c == 8'h10) mem.delete();
               if (a == u1 && c == 8'h10) busy = BUSY;
               win = (c == 8'h30);
               wc = W;
            end
         6: begin
               mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & d;
               busy = BUSY;
               n = 0;
            end
         7: begin
               byp = byp && c != 8'h00;
               n = 0;
            end
      endcase
   endtask
   always @(posedge flash_out.we_n)
      if (!flash_out.ce_n && flash_out.reset_n) wr(flash_out.addr, flash_dq_out[7:0], flash_dq_out);
   // timers, hardware reset and read data
   always @(posedge pclk) begin
      if (busy > 0) busy--;
      if (win) wc--;
      if (win && wc <= 0) busy = BUSY;
      if (win && wc <= 0) win = 0;
      if (!flash_out.reset_n) begin
         busy = 0;
         win = 0;
         n = 0;
         byp = 0;
      end
      if (flash_out.oe_n || flash_out.ce_n) flash_dq_in <= ~flash_dq_in;
      else if (busy != 0) flash_dq_in <= flash_dq_in ^ 16'h0040;
      else flash_dq_in <= mem.exists(flash_out.addr) ? mem[flash_out.addr] : 16'hFFFF;
   end
endmodule
`default_nettype wire

/* verification/fpc_host_test.sv */
// Purpose: self-checking bench of the flash command controller over APB
// Assumes: flash model on the far side, short erase window
// Notes:   every wait is bounded and a timeout counts as a mismatch
`timescale 1ns/1ps
`default_nettype none
module fpc_host_test;
   import fpc_pkg::*;
   logic           pclk = 0;
   logic           presetn = 0;
   logic           psel = 0;
   logic           penable = 0;
   logic           pwrite = 0;
   logic [7:0]     paddr = 8'h00;
   logic [31:0]    pwdata = 32'h0;
   logic [31:0]    prdata;
   logic [31:0]    q;
   logic           err;
   logic           pready;
   logic           pslverr;
   logic           flash_dq_oe;
   logic           ready_busy_out;
   logic [15:0]    flash_dq_out;
   logic [15:0]    flash_dq_in;
   fpc_flash_out_t flash_out;
   int             error_cnt = 0;
   int             tests_run = 0;
   fpc_host #(.WINDOW_CYCLES(200)) fpc_host_inst (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_out(flash_out),
      .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
      .ready_busy_out(ready_busy_out));
   fpc_flash_model #(.W(200)) fpc_flash_model_inst (.pclk(pclk), .flash_out(flash_out),
      .flash_dq_out(flash_dq_out), .flash_dq_in(flash_dq_in), .ready_busy_out(ready_busy_out));
   initial forever #2.5 pclk = ~pclk;
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         $display("[ERR] %0t got %h expected %h", $time, g, e);
         error_cnt++;
      end
   endtask
   // one apb transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
      if (i == 20) chk(32'h0, 32'h1);
      if (i == 20) end_of_test();
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cmd(input logic [3:0] c, input logic [21:0] a, input logic [15:0] d);
      apb(1'b1, 8'h04, {10'h000, a});
      apb(1'b1, 8'h08, {16'h0000, d});
      apb(1'b1, 8'h0C, {28'h0000000, c});
   endtask
   // poll status until any masked bit is set, or with s low until all are clear
   task automatic wait_st(input logic [31:0] m, input logic s = 1'b1);
      int i;
      for (i = 0; i < 2000; i++) begin
         apb(1'b0, 8'h10, 32'h0);
         if (((q & m) != 32'h0) == s) break;
      end
      if (i == 2000) chk(32'h0, m);
      if (i == 2000) end_of_test();
   endtask
   task automatic op(input logic [3:0] c, input logic [21:0] a, input logic [15:0] d);
      cmd(c, a, d);
      wait_st(32'h40);
      apb(1'b1, 8'h10, 32'h40);
   endtask
   task automatic stat(input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, 8'h10, 32'h0);
      chk(q & m, e);
      apb(1'b1, 8'h10, 32'hC0);
   endtask
   task automatic rdback(input logic [21:0] a, input logic [31:0] e);
      op(4'h8, a, 16'h0000);
      apb(1'b0, 8'h14, 32'h0);
      chk(q, e);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      stat(32'hFF, 32'h20);
      apb(1'b0, 8'h40, 32'h0);
      chk({q[31:1], err}, 32'h1);
      op(4'h0, 22'h000123, 16'h5A5A);
      op(4'h0, 22'h3F0001, 16'h1234);
      op(4'h0, 22'h000123, 16'hFFFF);
      rdback(22'h000123, 32'h5A5A);
      rdback(22'h3F0001, 32'h1234);
      cmd(4'h0, 22'h000400, 16'h0F0F);
      apb(1'b1, 8'h0C, 32'h0);
      wait_st(32'h40);
      stat(32'hC0, 32'hC0);
      rdback(22'h000400, 32'h0F0F);
      op(4'h1, 22'h000000, 16'h0000);
      stat(32'h02, 32'h02);
      op(4'h2, 22'h000200, 16'h00C3);
      cmd(4'h0, 22'h000201, 16'h0000);
      stat(32'h80, 32'h80);
      op(4'h3, 22'h000000, 16'h0000);
      stat(32'h02, 32'h00);
      rdback(22'h000200, 32'h00C3);
      apb(1'b1, 8'h00, 32'h2);
      stat(32'h02, 32'h02);
      op(4'h2, 22'h000300, 16'h0011);
      apb(1'b1, 8'h00, 32'h1);
      op(4'h0, 22'h000500, 16'hBEEF);
      rdback(22'h000500, 32'h00EF);
      apb(1'b1, 8'h00, 32'h0);
      rdback(22'h000300, 32'h0011);
      cmd(4'h4, 22'h000000, 16'h0000);
      cmd(4'h7, 22'h000000, 16'h0000);
      wait_st(32'h40);
      stat(32'h90, 32'h80);
      rdback(22'h000123, 32'hFFFF);
      cmd(4'h5, 22'h010000, 16'h0000);
      wait_st(32'h08);
      cmd(4'h6, 22'h020000, 16'h0000);
      wait_st(32'h04, 1'b0);
      stat(32'h8C, 32'h00);
      cmd(4'h5, 22'h010000, 16'h0000);
      wait_st(32'h08);
      cmd(4'h7, 22'h000000, 16'h0000);
      wait_st(32'h10);
      stat(32'h0C, 32'h00);
      op(4'h9, 22'h000000, 16'h0000);
      stat(32'h10, 32'h00);
      cmd(4'h0, 22'h000600, 16'h0000);
      op(4'h9, 22'h000600, 16'h0000);
      rdback(22'h000600, 32'hFFFF);
      end_of_test();
   end
endmodule
`default_nettype wire
